/* File: verilog/mcsp_defs.vh */
// Shared constants for the multichannel serial port
`ifndef MCSP_DEFS_VH
`define MCSP_DEFS_VH
// Word length codes
`define MCSP_WL_8 3'h0
`define MCSP_WL_12 3'h1
`define MCSP_WL_16 3'h2
`define MCSP_WL_20 3'h3
`define MCSP_WL_24 3'h4
`define MCSP_WL_32 3'h5
// Companding codes
`define MCSP_CMP_OFF 2'h0
`define MCSP_CMP_MU 2'h1
`define MCSP_CMP_A 2'h2
// Rate generator reference select
`define MCSP_REF_CPU 2'h0
`define MCSP_REF_GEN 2'h1
`define MCSP_REF_RXC 2'h2
`define MCSP_REF_TXC 2'h3
// Channel and frame limits
`define MCSP_MAX_CHAN 128
`define MCSP_CHAN_BLOCK 32
`define MCSP_FIELD_BITS 1024
`define MCSP_FIELD_WORD 16
// Clock ratio limit: bit clock at most half the system clock
`define MCSP_MIN_DIV 8'h02
// Pin index for general purpose mode
`define MCSP_PIN_REF 0
`define MCSP_PIN_TXD 1
`define MCSP_PIN_RXD 2
`define MCSP_PIN_TFS 3
`define MCSP_PIN_RFS 4
`define MCSP_PIN_TXC 5
`define MCSP_PIN_RXC 6
`define MCSP_NPINS 7
// Transmit buffer depth
`define MCSP_FIFO_DEPTH 32
`endif

/* File: verilog/mcsp_mem.v */
// Dual port word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module mcsp_mem #(
   parameter WIDTH = 32,
   parameter AW = 5
) (
   // Clock
   input wire clk_sys,
   // Write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [WIDTH-1:0] wr_data,
   // Read port
   input wire [AW-1:0] rd_addr,
   output reg [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [0:(1<<AW)-1];
   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // mcsp_mem
`default_nettype wire

/* File: verilog/mcsp_fifo.v */
// Valid/ready FIFO over a registered memory
`timescale 1ns/1ps
`default_nettype none
module mcsp_fifo #(
   parameter WIDTH = 32,
   parameter AW = 5
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output reg out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire [AW:0] count = wr_ptr - rd_ptr;
   // Last slot kept for the word held at the output
   wire full = (count == (1 << AW) - 1);
   wire empty = (count == {(AW+1){1'b0}});
   wire push = in_valid && !full;
   // Read when output slot is free or being drained
   wire pop = !empty && (!out_valid || out_ready);
   // Reread the held word's slot until the next pop
   wire [AW-1:0] rd_sel = pop ? rd_ptr[AW-1:0] : rd_ptr[AW-1:0] - 1'b1;
   assign in_ready = !full;
   mcsp_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (
      .clk_sys(clk_sys),
      .wr_en(push),
      .wr_addr(wr_ptr[AW-1:0]),
      .wr_data(in_data),
      .rd_addr(rd_sel),
      .rd_data(out_data)
   );
   always @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule // mcsp_fifo
`default_nettype wire

/* File: verilog/mcsp_port.v */
// Multichannel buffered serial port core
`timescale 1ns/1ps
`default_nettype none
`include "mcsp_defs.vh"
module mcsp_port #(
   parameter DEPTH_AW = 5
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Configuration
   input wire [15:0] cfg_ctrl,
   input wire [15:0] cfg_frame,
   input wire [15:0] cfg_srg,
   input wire [15:0] cfg_pin,
   input wire [127:0] rx_chan_en,
   input wire [127:0] tx_chan_en,
   input wire [1023:0] field_pattern,
   // Receive data register
   output reg [15:0] rx_data_reg,
   output reg [15:0] rx_data_hi,
   output reg rx_data_valid,
   input wire rx_data_rd,
   output reg rx_overrun,
   input wire rx_overrun_clr,
   // Transmit data register
   input wire [15:0] tx_data_reg,
   input wire [15:0] tx_data_hi,
   input wire tx_data_wr,
   output reg tx_ready,
   // Notifications
   output reg rx_irq,
   output reg tx_irq,
   output reg rx_event,
   output reg tx_event,
   output reg rx_event_alt,
   output reg tx_event_alt,
   // Serial pins, inputs
   input wire gen_ref_clock_pin,
   input wire serial_rx_pin,
   input wire rx_frame_sync_in,
   input wire tx_frame_sync_in,
   input wire rx_bit_clock_in,
   input wire tx_bit_clock_in,
   input wire serial_tx_in,
   // Serial pins, outputs and enables
   output reg serial_tx_pin,
   output reg serial_tx_oe,
   output reg tx_frame_sync_pin,
   output reg tx_frame_sync_oe,
   output reg rx_frame_sync_pin,
   output reg rx_frame_sync_oe,
   output reg tx_bit_clock_pin,
   output reg tx_bit_clock_oe,
   output reg rx_bit_clock_pin,
   output reg rx_bit_clock_oe,
   // General purpose view of pins
   output reg [6:0] gpio_in
);
   ////////////////////////////////////////////////////////////////////
   // Configuration fields
   wire rx_en = cfg_ctrl[0];
   wire tx_en = cfg_ctrl[1];
   wire [2:0] wl = cfg_ctrl[4:2];
   wire [1:0] cmp = cfg_ctrl[6:5];
   wire lsb_first = cfg_ctrl[7];
   wire clock_halt_mode = cfg_ctrl[8];
   wire field_mode = cfg_ctrl[9];
   wire multichan = cfg_ctrl[10];
   wire block_mode = cfg_ctrl[11];
   wire [1:0] blk_sel = cfg_ctrl[13:12];
   wire [2:0] fs_pol = {1'b0, cfg_frame[1:0]};
   wire rclk_pol = cfg_frame[2];
   wire xclk_pol = cfg_frame[3];
   wire rclk_int = cfg_frame[4];
   wire xclk_int = cfg_frame[5];
   wire rfs_int = cfg_frame[6];
   wire xfs_int = cfg_frame[7];
   wire [6:0] chans = cfg_frame[14:8];
   wire [1:0] ref_sel = cfg_srg[1:0];
   wire [7:0] div_raw = cfg_srg[9:2];
   wire [5:0] fs_per = cfg_srg[15:10];
   wire [6:0] gp_oe = cfg_pin[6:0];
   wire [6:0] gp_out = cfg_pin[13:7];

   // Half-rate clamp on the divider
   wire [7:0] div = (div_raw < `MCSP_MIN_DIV) ? `MCSP_MIN_DIV : div_raw;
   // Halt mode forces one word per frame, one role
   wire one_word = clock_halt_mode || (chans == 7'h00);
   wire tx_master = clock_halt_mode ? rclk_int : xclk_int;
   wire rx_master = rclk_int;

   function [5:0] wl_bits;
      input [2:0] code;
      begin
         case (code)
            `MCSP_WL_8: wl_bits = 6'h08;
            `MCSP_WL_12: wl_bits = 6'h0C;
            `MCSP_WL_16: wl_bits = 6'h10;
            `MCSP_WL_20: wl_bits = 6'h14;
            `MCSP_WL_24: wl_bits = 6'h18;
            default: wl_bits = 6'h20;
         endcase
      end
   endfunction
   wire [5:0] nbits = field_mode ? 6'h01 : wl_bits(wl);

   // Channel enable lookup, single or block of 32
   function chan_ok;
      input [127:0] map;
      input [6:0] ch;
      input blk;
      input [1:0] bs;
      begin
         if (blk) begin
            chan_ok = (ch[6:5] == bs);
         end else begin
            chan_ok = map[ch];
         end
      end
   endfunction

   // Compression of a 16-bit linear sample
   function [7:0] compress;
      input [15:0] s;
      input alaw;
      reg sg;
      reg [15:0] m;
      reg [2:0] e;
      reg [3:0] q;
      integer i;
      begin
         sg = s[15];
         m = sg ? (~s + 16'h0001) : s;
         if (!alaw) begin
            m = (m > 16'h7F7B) ? 16'h7F7B : m;
            m = m + 16'h0084;
         end
         e = 3'h0;
         for (i = 7; i >= 1; i = i - 1) begin
            if (e == 3'h0 && m[i+7]) begin
               e = i[2:0];
            end
         end
         q = (e == 3'h0 && alaw) ? m[7:4] : m[e+3 +: 4];
         if (alaw) begin
            compress = {~sg, e, q} ^ 8'h55;
         end else begin
            compress = ~{sg, e, q};
         end
      end
   endfunction

   // Expansion to 16-bit two's complement
   function [15:0] expand;
      input [7:0] c;
      input alaw;
      reg [7:0] v;
      reg [15:0] m;
      begin
         v = alaw ? (c ^ 8'h55) : ~c;
         if (alaw) begin
            m = (v[6:4] == 3'h0) ? {8'h00, v[3:0], 4'h8} :
               ({7'h00, 1'b1, v[3:0], 4'h8} << (v[6:4] - 3'h1));
            expand = v[7] ? m : (~m + 16'h0001);
         end else begin
            m = ({8'h00, 1'b1, v[3:0], 3'h4} << v[6:4]) - 16'h0084;
            expand = v[7] ? (~m + 16'h0001) : m;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, change on agreement
   reg [6:0] s1;
   reg [6:0] s2;
   reg [6:0] s3;
   reg [6:0] pin;
   wire [6:0] raw = {rx_bit_clock_in, tx_bit_clock_in, rx_frame_sync_in,
      tx_frame_sync_in, serial_rx_pin, serial_tx_in, gen_ref_clock_pin};
   always @(posedge clk_sys) begin
      if (rst) begin
         s1 <= 7'h00;
         s2 <= 7'h00;
         s3 <= 7'h00;
         pin <= 7'h00;
         gpio_in <= 7'h00;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         pin <= (s2 & s3) | (pin & (s2 | s3));
         gpio_in <= pin;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sample rate generator
   reg [7:0] div_cnt;
   reg [5:0] fs_cnt;
   reg gclk;
   reg gfs;
   reg ref_d;
   wire ref_lvl = (ref_sel == `MCSP_REF_GEN) ? pin[`MCSP_PIN_REF] :
      (ref_sel == `MCSP_REF_RXC) ? pin[`MCSP_PIN_RXC] :
      pin[`MCSP_PIN_TXC];
   wire ref_tick = (ref_sel == `MCSP_REF_CPU) || (ref_lvl && !ref_d);
   always @(posedge clk_sys) begin
      if (rst) begin
         div_cnt <= 8'h00;
         fs_cnt <= 6'h00;
         gclk <= 1'b0;
         gfs <= 1'b0;
         ref_d <= 1'b0;
      end else begin
         ref_d <= ref_lvl;
         if (ref_tick) begin
            if (div_cnt >= div - 8'h01) begin
               div_cnt <= 8'h00;
               gclk <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 8'h01;
               if (div_cnt == (div >> 1) - 8'h01) begin
                  gclk <= 1'b0;
               end
            end
            if (div_cnt == 8'h00 && gclk) begin
               fs_cnt <= (fs_cnt == fs_per) ? 6'h00 : fs_cnt + 6'h01;
               gfs <= (fs_cnt == fs_per);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Clock and sync selection per direction
   wire rclk = rclk_int ? gclk : (pin[`MCSP_PIN_RXC] ^ rclk_pol);
   wire xclk = tx_master ? gclk : (pin[`MCSP_PIN_TXC] ^ xclk_pol);
   wire rfs = rfs_int ? gfs : (pin[`MCSP_PIN_RFS] ^ fs_pol[0]);
   wire xfs = xfs_int ? gfs : (pin[`MCSP_PIN_TFS] ^ fs_pol[1]);
   reg rclk_d;
   reg xclk_d;
   always @(posedge clk_sys) begin
      if (rst) begin
         rclk_d <= 1'b0;
         xclk_d <= 1'b0;
      end else begin
         rclk_d <= rclk;
         xclk_d <= xclk;
      end
   end
   wire r_smp = rclk && !rclk_d;
   wire x_drv = !xclk && xclk_d;

   ////////////////////////////////////////////////////////////////////
   // Receiver
   reg [31:0] rsr;
   reg [5:0] rbit;
   reg [6:0] rch;
   reg [9:0] rpos;
   reg ract;
   reg [31:0] rbuf;
   reg rbuf_full;
   wire r_take = field_mode ? field_pattern[rpos] :
      (!multichan || chan_ok(rx_chan_en, rch, block_mode, blk_sel));
   wire [31:0] rword = (wl == `MCSP_WL_8 && lsb_first) ?
      {24'h000000, rsr[0], rsr[1], rsr[2], rsr[3],
      rsr[4], rsr[5], rsr[6], rsr[7]} : rsr;
   wire [31:0] rlin = (cmp != `MCSP_CMP_OFF) ?
      {16'h0000, expand(rword[7:0], cmp == `MCSP_CMP_A)} : rword;
   reg r_done;
   reg r_end;
   always @(posedge clk_sys) begin
      if (rst) begin
         rsr <= 32'h00000000;
         rbit <= 6'h00;
         rch <= 7'h00;
         rpos <= 10'h000;
         ract <= 1'b0;
         r_done <= 1'b0;
         r_end <= 1'b0;
      end else begin
         r_done <= 1'b0;
         r_end <= 1'b0;
         if (rx_en && r_smp) begin
            if (rfs) begin
               ract <= 1'b1;
               rbit <= 6'h00;
               rch <= 7'h00;
               rpos <= 10'h000;
               rsr <= 32'h00000000;
            end else if (ract) begin
               if (field_mode) begin
                  if (r_take) begin
                     rsr <= {rsr[30:0], pin[`MCSP_PIN_RXD]};
                     rbit <= rbit + 6'h01;
                     r_done <= (rbit == 6'h0F);
                     if (rbit == 6'h0F) begin
                        rbit <= 6'h00;
                     end
                  end
                  rpos <= rpos + 10'h001;
                  if (rpos == 10'h3FF) begin
                     ract <= 1'b0;
                     r_end <= 1'b1;
                  end
               end else begin
                  rsr <= {rsr[30:0], pin[`MCSP_PIN_RXD]};
                  if (rbit == nbits - 6'h01) begin
                     rbit <= 6'h00;
                     r_done <= r_take;
                     rch <= rch + 7'h01;
                     if (one_word || rch == chans) begin
                        ract <= 1'b0;
                        r_end <= 1'b1;
                     end
                  end else begin
                     rbit <= rbit + 6'h01;
                  end
               end
            end
         end
      end
   end
   // Shift register to buffer to data register
   always @(posedge clk_sys) begin
      if (rst) begin
         rbuf <= 32'h00000000;
         rbuf_full <= 1'b0;
         rx_data_reg <= 16'h0000;
         rx_data_hi <= 16'h0000;
         rx_data_valid <= 1'b0;
         rx_overrun <= 1'b0;
      end else begin
         if (r_done) begin
            rbuf <= rlin;
            rbuf_full <= 1'b1;
         end else if (rbuf_full && (!rx_data_valid || rx_data_rd)) begin
            rbuf_full <= 1'b0;
         end
         if (rbuf_full && (!rx_data_valid || rx_data_rd)) begin
            rx_data_reg <= rbuf[15:0];
            rx_data_hi <= rbuf[31:16];
            rx_data_valid <= 1'b1;
         end else if (rx_data_rd) begin
            rx_data_valid <= 1'b0;
         end
         if (r_done && rbuf_full && rx_data_valid && !rx_data_rd) begin
            rx_overrun <= 1'b1;
         end else if (rx_overrun_clr) begin
            rx_overrun <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transmit buffer
   wire f_valid;
   wire [31:0] f_data;
   wire f_in_ready;
   reg f_take;
   mcsp_fifo #(.WIDTH(32), .AW(DEPTH_AW)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(tx_data_wr),
      .in_ready(f_in_ready),
      .in_data({tx_data_hi, tx_data_reg}),
      .out_valid(f_valid),
      .out_ready(f_take),
      .out_data(f_data)
   );

   // Transmitter
   reg [31:0] xsr;
   reg [5:0] xbit;
   reg [6:0] xch;
   reg [9:0] xpos;
   reg xact;
   reg xload;
   wire x_take = field_mode ? field_pattern[xpos] :
      (!multichan || chan_ok(tx_chan_en, xch, block_mode, blk_sel));
   wire [31:0] xcmp = (cmp != `MCSP_CMP_OFF) ?
      {compress(f_data[15:0], cmp == `MCSP_CMP_A), 24'h000000} : f_data;
   wire [31:0] xal = (cmp != `MCSP_CMP_OFF) ? xcmp :
      (field_mode ? {f_data[15:0], 16'h0000} :
      (f_data << (6'h20 - nbits)));
   wire [31:0] xword = (wl == `MCSP_WL_8 && lsb_first && !field_mode) ?
      {f_data[0], f_data[1], f_data[2], f_data[3], f_data[4], f_data[5],
      f_data[6], f_data[7], 24'h000000} : xal;
   always @(posedge clk_sys) begin
      if (rst) begin
         xsr <= 32'h00000000;
         xbit <= 6'h00;
         xch <= 7'h00;
         xpos <= 10'h000;
         xact <= 1'b0;
         xload <= 1'b1;
         f_take <= 1'b0;
         tx_ready <= 1'b0;
         tx_irq <= 1'b0;
         tx_event <= 1'b0;
         tx_event_alt <= 1'b0;
         serial_tx_pin <= 1'b0;
         serial_tx_oe <= 1'b0;
      end else begin
         f_take <= 1'b0;
         tx_irq <= 1'b0;
         tx_event <= 1'b0;
         tx_event_alt <= 1'b0;
         tx_ready <= f_in_ready;
         if (xload && f_valid && !f_take) begin
            xsr <= xword;
            xload <= 1'b0;
            f_take <= 1'b1;
         end
         if (tx_en && x_drv) begin
            if (xfs) begin
               xact <= 1'b1;
               xbit <= 6'h00;
               xch <= 7'h00;
               xpos <= 10'h000;
            end else if (xact) begin
               serial_tx_oe <= x_take;
               if (x_take) begin
                  serial_tx_pin <= xsr[31];
                  xsr <= {xsr[30:0], 1'b0};
               end
               if (field_mode) begin
                  xpos <= xpos + 10'h001;
                  if (x_take) begin
                     xbit <= (xbit == 6'h0F) ? 6'h00 : xbit + 6'h01;
                     if (xbit == 6'h0F) begin
                        xload <= 1'b1;
                        tx_irq <= 1'b1;
                        tx_event <= 1'b1;
                     end
                  end
                  if (xpos == 10'h3FF) begin
                     xact <= 1'b0;
                     tx_irq <= 1'b1;
                     tx_event_alt <= 1'b1;
                  end
               end else if (xbit == nbits - 6'h01) begin
                  xbit <= 6'h00;
                  xch <= xch + 7'h01;
                  xload <= x_take || xload;
                  tx_irq <= x_take;
                  tx_event <= x_take;
                  if (one_word || xch == chans) begin
                     xact <= 1'b0;
                     tx_event_alt <= 1'b1;
                  end
               end else begin
                  xbit <= xbit + 6'h01;
               end
            end else begin
               serial_tx_oe <= 1'b0;
            end
         end
         if (!tx_en && gp_oe[`MCSP_PIN_TXD]) begin
            serial_tx_oe <= 1'b1;
            serial_tx_pin <= gp_out[`MCSP_PIN_TXD];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Receive notifications and pin drivers
   always @(posedge clk_sys) begin
      if (rst) begin
         rx_irq <= 1'b0;
         rx_event <= 1'b0;
         rx_event_alt <= 1'b0;
         tx_frame_sync_pin <= 1'b0;
         tx_frame_sync_oe <= 1'b0;
         rx_frame_sync_pin <= 1'b0;
         rx_frame_sync_oe <= 1'b0;
         tx_bit_clock_pin <= 1'b0;
         tx_bit_clock_oe <= 1'b0;
         rx_bit_clock_pin <= 1'b0;
         rx_bit_clock_oe <= 1'b0;
      end else begin
         rx_irq <= r_done || (field_mode && r_end);
         rx_event <= r_done;
         rx_event_alt <= r_end;
         tx_frame_sync_oe <= xfs_int || (!tx_en && gp_oe[`MCSP_PIN_TFS]);
         tx_frame_sync_pin <= xfs_int ? (gfs ^ fs_pol[1]) :
            gp_out[`MCSP_PIN_TFS];
         rx_frame_sync_oe <= rfs_int || (!rx_en && gp_oe[`MCSP_PIN_RFS]);
         rx_frame_sync_pin <= rfs_int ? (gfs ^ fs_pol[0]) :
            gp_out[`MCSP_PIN_RFS];
         tx_bit_clock_oe <= tx_master || (!tx_en && gp_oe[`MCSP_PIN_TXC]);
         tx_bit_clock_pin <= tx_master ? (gclk ^ xclk_pol) :
            gp_out[`MCSP_PIN_TXC];
         rx_bit_clock_oe <= rx_master || (!rx_en && gp_oe[`MCSP_PIN_RXC]);
         rx_bit_clock_pin <= rx_master ? (gclk ^ rclk_pol) :
            gp_out[`MCSP_PIN_RXC];
      end
   end
endmodule // mcsp_port
`default_nettype wire

/* File: verification/mcsp_monitor.sv */
// Assertion checker for the multichannel serial port
`timescale 1ns/1ps
`default_nettype none
module mcsp_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Watched ports
   input wire logic [15:0] cfg_ctrl,
   input wire logic [15:0] cfg_frame,
   input wire logic [15:0] cfg_pin,
   input wire logic rx_data_valid,
   input wire logic rx_data_rd,
   input wire logic rx_overrun,
   input wire logic rx_overrun_clr,
   input wire logic rx_irq,
   input wire logic tx_irq,
   input wire logic rx_event,
   input wire logic serial_rx_pin,
   input wire logic serial_tx_pin,
   input wire logic serial_tx_oe,
   input wire logic rx_bit_clock_oe,
   input wire logic [6:0] gpio_in
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Word waiting in the second receive stage
   logic held;
   always @(posedge clk_sys) begin
      if (rst) begin
         held <= 1'b0;
      end else begin
         held <= (held || rx_event) && rx_data_valid && !rx_data_rd;
      end
   end
   ////////////////////////////////////////
   a_rx_irq_pulse: assert property (rx_irq |=> !rx_irq)
      else $error("rx_irq wider than one cycle");
   a_tx_irq_pulse: assert property (tx_irq |=> !tx_irq)
      else $error("tx_irq wider than one cycle");
   a_irq_with_valid: assert property (rx_irq && rx_event
      |=> rx_data_valid)
      else $error("rx_irq without valid data");
   a_read_clears: assert property (rx_data_valid && rx_data_rd
      && !held && !rx_event |=> !rx_data_valid)
      else $error("read did not clear valid");
   a_overrun_sticky: assert property (rx_overrun && !rx_overrun_clr
      |=> rx_overrun)
      else $error("overrun dropped without clear");
   a_overrun_cause: assert property ($rose(rx_overrun)
      |-> $past(rx_data_valid))
      else $error("overrun without unread word");
   a_rx_off_quiet: assert property ((!cfg_ctrl[0])[*8]
      |-> !rx_irq && !rx_event)
      else $error("receive event while disabled");
   a_ext_clk_input: assert property (!cfg_frame[4] && !cfg_pin[6]
      |=> !rx_bit_clock_oe)
      else $error("external bit clock pin driven");
   a_gp_drive: assert property ((cfg_pin[1] && !cfg_ctrl[1])[*3]
      |-> serial_tx_oe && serial_tx_pin == cfg_pin[8])
      else $error("general output not driven");
   a_gp_sample: assert property ($stable(serial_rx_pin)[*6]
      |-> gpio_in[2] == serial_rx_pin)
      else $error("general input level wrong");
   c_rx_word: cover property (rx_irq);
   c_overrun: cover property ($rose(rx_overrun));
   c_tx_word: cover property (tx_irq);
endmodule // mcsp_monitor
bind mcsp_port mcsp_monitor u_mon (.clk_sys, .rst, .cfg_ctrl, .cfg_frame,
   .cfg_pin, .rx_data_valid, .rx_data_rd, .rx_overrun, .rx_overrun_clr,
   .rx_irq, .tx_irq, .rx_event, .serial_rx_pin, .serial_tx_pin,
   .serial_tx_oe, .rx_bit_clock_oe, .gpio_in);
`default_nettype wire

/* File: verification/mcsp_codec.sv */
// Far-side serial device: frames words in, captures words out
`timescale 1ns/1ps
`default_nettype none
module mcsp_codec (
   // Toward the receiver
   output logic rx_clk,
   output logic rx_fs,
   output logic rx_dat,
   // Toward the transmitter
   output logic tx_clk,
   output logic tx_fs,
   input wire logic tx_dat
);
   initial begin
      rx_clk = 0;
      rx_fs = 0;
      rx_dat = 0;
      tx_clk = 0;
      tx_fs = 0;
   end
   // 48 ns bit clock, still between frames
   task automatic send(input logic [7:0] w, input logic fp, input logic lsb);
      int i;
      rx_fs = fp;
      #24 rx_clk = 1;
      #24 rx_clk = 0;
      rx_fs = !fp;
      for (i = 0; i < 8; i++) begin
         rx_dat = lsb ? w[i] : w[7-i];
         #24 rx_clk = 1;
         #24 rx_clk = 0;
      end
      rx_dat = !rx_dat;
   endtask
   task automatic recv(output logic [7:0] w);
      int i;
      tx_fs = 1;
      #24 tx_clk = 1;
      // Sync held over the falling edge that starts the frame
      #24 tx_clk = 0;
      #24 tx_clk = 1;
      tx_fs = 0;
      for (i = 7; i >= 0; i--) begin
         #24 tx_clk = 0;
         #24 tx_clk = 1;
         w[i] = tx_dat;
      end
      #24 tx_clk = 0;
   endtask
endmodule // mcsp_codec
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the multichannel serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys, rst, rx_data_rd, rx_overrun_clr, tx_data_wr;
   logic [15:0] cfg_ctrl, cfg_frame, cfg_srg, cfg_pin, tx_data_reg;
   logic [127:0] chan_en;
   logic [1023:0] pattern;
   logic [7:0] got;
   wire logic [15:0] rx_data_reg;
   wire logic [6:0] gpio_in;
   wire logic rx_data_valid, rx_overrun, tx_ready, rx_irq, tx_irq;
   wire logic serial_tx_pin, serial_tx_oe, rclk, rfs, rdat, tclk, tfs;
   // Pulled-up data line when the port lets go
   wire logic txd = serial_tx_oe ? serial_tx_pin : 1'b1;
   int fails = 0;
   int n_checks = 0;
   int n_irq = 0;
   int i;
   mcsp_codec codec (.rx_clk(rclk), .rx_fs(rfs), .rx_dat(rdat),
      .tx_clk(tclk), .tx_fs(tfs), .tx_dat(txd));
   mcsp_port DUT (.clk_sys, .rst, .cfg_ctrl, .cfg_frame, .cfg_srg, .cfg_pin,
      .rx_chan_en(chan_en), .tx_chan_en(chan_en), .field_pattern(pattern),
      .rx_data_reg, .rx_data_hi(), .rx_data_valid, .rx_data_rd, .rx_overrun,
      .rx_overrun_clr, .tx_data_reg, .tx_data_hi(16'h0000), .tx_data_wr,
      .tx_ready, .rx_irq, .tx_irq, .rx_event(), .tx_event(),
      .rx_event_alt(), .tx_event_alt(), .gen_ref_clock_pin(1'b0),
      .serial_rx_pin(rdat), .rx_frame_sync_in(rfs), .tx_frame_sync_in(tfs),
      .rx_bit_clock_in(rclk), .tx_bit_clock_in(tclk), .serial_tx_in(txd),
      .serial_tx_pin, .serial_tx_oe, .tx_frame_sync_pin(),
      .tx_frame_sync_oe(), .rx_frame_sync_pin(), .rx_frame_sync_oe(),
      .tx_bit_clock_pin(), .tx_bit_clock_oe(), .rx_bit_clock_pin(),
      .rx_bit_clock_oe(), .gpio_in);
   initial begin
      clk_sys = 0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (rx_irq === 1'b1) n_irq <= n_irq + 1;
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] e, s);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rx_take(input logic [15:0] e);
      int k;
      for (k = 0; k < 40 && rx_data_valid !== 1'b1; k++) @(negedge clk_sys);
      chk("rx_data_reg", e, rx_data_reg);
      @(negedge clk_sys) rx_data_rd = 1;
      @(negedge clk_sys) rx_data_rd = 0;
   endtask
   task automatic rx_word(input logic [7:0] w, input logic fp, lsb);
      codec.send(w, fp, lsb);
      rx_take({8'h00, w});
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      close_out;
   end
   ////////////////////////////////////////
   initial begin
      rst = 1;
      cfg_ctrl = 16'h0001;
      cfg_frame = 16'h0000;
      cfg_srg = 16'h0030;
      cfg_pin = 16'h0000;
      chan_en = '1;
      pattern = '0;
      {rx_data_rd, rx_overrun_clr, tx_data_wr} = 3'h0;
      tx_data_reg = 16'h0000;
      repeat (8) @(negedge clk_sys);
      rst = 0;
      repeat (2) @(negedge clk_sys);
      rx_word(8'hA5, 1, 0);
      chk("rx_irq count", 16'h0001, n_irq[15:0]);
      codec.send(8'h3C, 1, 0);
      codec.send(8'h96, 1, 0);
      codec.send(8'hC3, 1, 0);
      chk("rx_overrun", 16'h0001, {15'h0000, rx_overrun});
      rx_take(16'h003C);
      rx_take(16'h00C3);
      @(negedge clk_sys) rx_overrun_clr = 1;
      @(negedge clk_sys) rx_overrun_clr = 0;
      chk("rx_overrun", 16'h0000, {15'h0000, rx_overrun});
      cfg_ctrl = 16'h0081;
      rx_word(8'h1E, 1, 1);
      cfg_ctrl = 16'h0001;
      cfg_frame = 16'h0001;
      rx_word(8'h5A, 0, 0);
      cfg_frame = 16'h0000;
      cfg_ctrl = 16'h0021;
      codec.send(8'h80, 1, 0);
      rx_take(16'h7D7C);
      cfg_ctrl = 16'h0001;
      cfg_pin = 16'h0002;
      repeat (8) @(negedge clk_sys);
      chk("serial_tx_pin", 16'h0000, {15'h0000, txd});
      chk("gpio_in", 16'h0001, {15'h0000, gpio_in[2]});
      cfg_pin = 16'h0000;
      for (i = 0; i < 33; i++) begin
         tx_data_reg = 16'h0040 + i[15:0];
         tx_data_wr = 1;
         @(negedge clk_sys) tx_data_wr = 0;
         @(negedge clk_sys);
      end
      chk("tx_ready", 16'h0000, {15'h0000, tx_ready});
      cfg_ctrl = 16'h0002;
      codec.send(8'h11, 1, 0);
      repeat (4) @(negedge clk_sys);
      chk("rx_data_valid", 16'h0000, {15'h0000, rx_data_valid});
      for (i = 0; i < 32; i++) begin
         codec.recv(got);
         chk("tx word", 16'h0040 + i[15:0], {8'h00, got});
      end
      repeat (4) @(negedge clk_sys);
      chk("tx_ready", 16'h0001, {15'h0000, tx_ready});
      close_out;
   end
endmodule // testbench
`default_nettype wire
